// ---- design/backup_rtc_pkg.sv ----
package backup_rtc_pkg;

    // ========================================================================
    // register addresses
    // ========================================================================
    localparam logic [31:0] ADDR_IRQ_ENABLE_CTRL    = 32'h4000_2800;
    localparam logic [31:0] ADDR_FLAGS_CONFIG_CTRL  = 32'h4000_2804;
    localparam logic [31:0] ADDR_PRESCALE_UPPER     = 32'h4000_2808;
    localparam logic [31:0] ADDR_PRESCALE_LOWER     = 32'h4000_280c;
    localparam logic [31:0] ADDR_DIVIDER_UPPER      = 32'h4000_2810;
    localparam logic [31:0] ADDR_DIVIDER_LOWER      = 32'h4000_2814;
    localparam logic [31:0] ADDR_TIME_COUNTER_UPPER = 32'h4000_2818;
    localparam logic [31:0] ADDR_TIME_COUNTER_LOWER = 32'h4000_281c;
    localparam logic [31:0] ADDR_ALARM_VALUE_UPPER  = 32'h4000_2820;
    localparam logic [31:0] ADDR_ALARM_VALUE_LOWER  = 32'h4000_2824;

    // word index of each register inside the block
    localparam logic [3:0]  IDX_IRQ_ENABLE          = ADDR_IRQ_ENABLE_CTRL[5:2];
    localparam logic [3:0]  IDX_FLAGS_CONFIG        = ADDR_FLAGS_CONFIG_CTRL[5:2];
    localparam logic [3:0]  IDX_PRESCALE_UPPER      = ADDR_PRESCALE_UPPER[5:2];
    localparam logic [3:0]  IDX_PRESCALE_LOWER      = ADDR_PRESCALE_LOWER[5:2];
    localparam logic [3:0]  IDX_DIVIDER_UPPER       = ADDR_DIVIDER_UPPER[5:2];
    localparam logic [3:0]  IDX_DIVIDER_LOWER       = ADDR_DIVIDER_LOWER[5:2];
    localparam logic [3:0]  IDX_COUNTER_UPPER       = ADDR_TIME_COUNTER_UPPER[5:2];
    localparam logic [3:0]  IDX_COUNTER_LOWER       = ADDR_TIME_COUNTER_LOWER[5:2];
    localparam logic [3:0]  IDX_ALARM_UPPER         = ADDR_ALARM_VALUE_UPPER[5:2];
    localparam logic [3:0]  IDX_ALARM_LOWER         = ADDR_ALARM_VALUE_LOWER[5:2];
    localparam logic [3:0]  IDX_NONE                = 4'hf;

    // ========================================================================
    // field positions
    // ========================================================================
    localparam int SECOND_BIT      = 0;
    localparam int ALARM_BIT       = 1;
    localparam int OVERFLOW_BIT    = 2;
    localparam int SYNC_FLAG_BIT   = 3;
    localparam int CONFIG_MODE_BIT = 4;
    localparam int WRITE_DONE_BIT  = 5;
    localparam int RELOAD_UPPER_W  = 4;
    localparam int PRESCALE_W      = 20;

    // staging slots for writes made in configuration mode
    localparam int SLOT_RELOAD_UPPER  = 0;
    localparam int SLOT_RELOAD_LOWER  = 1;
    localparam int SLOT_COUNTER_UPPER = 2;
    localparam int SLOT_COUNTER_LOWER = 3;
    localparam int SLOT_ALARM_UPPER   = 4;
    localparam int SLOT_ALARM_LOWER   = 5;
    localparam int SLOT_COUNT         = 6;

    // ========================================================================
    // reset values
    // ========================================================================
    localparam logic [2:0]  RESET_IRQ_ENABLE  = 3'h0;
    localparam logic [2:0]  RESET_EVENT_FLAGS = 3'h0;
    localparam logic [19:0] RESET_RELOAD      = 20'h00000;
    localparam logic [19:0] RESET_DIVIDER     = 20'h00000;
    localparam logic [31:0] RESET_COUNTER     = 32'h0000_0000;
    localparam logic [15:0] RESET_ALARM_HALF  = 16'hffff;
    localparam logic [31:0] COUNTER_MAX       = 32'hffff_ffff;

endpackage : backup_rtc_pkg

// ---- design/rtc_clock_sync.sv ----
`timescale 1ns/10ps

// three-stage synchroniser for the rtc input clock with rising-edge pulse
module rtc_clock_sync (
    input  wire logic i_clk_sys,
    input  wire logic i_srst,
    input  wire logic i_rtc_input_clock,
    output logic      o_rtc_rise
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic rise;
    } sync_state_type;

    sync_state_type q;
    sync_state_type d;

    // ========================================================================
    // next state: level follows once stages two and three agree
    // ========================================================================
    always_comb begin
        d       = q;
        d.s1    = i_rtc_input_clock;
        d.s2    = q.s1;
        d.s3    = q.s2;
        d.level = (q.s2 == q.s3) ? q.s3 : q.level;
        d.rise  = d.level & ~q.level;
        if (i_srst) begin
            d = '0;
        end
    end

    // state register
    always_ff @(posedge i_clk_sys) begin
        q <= d;
    end

    assign o_rtc_rise = q.rise;

endmodule : rtc_clock_sync

// ---- design/backup_domain_rtc.sv ----
`timescale 1ns/10ps

// Notes on behaviour
// - divider counts down per rtc edge, ticks at zero and reloads
// - tick period is reload value plus one rtc edges
// - reload split: four upper bits and sixteen lower bits
// - each tick adds one to the time counter with the second event
// - time counter is 32 bits read as two 16-bit halves
// - tick sets second flag bit 0, irq when its enable set
// - counter equal to alarm sets alarm flag bit 1, irq if enabled
// - counter wrap sets overflow flag bit 2, irq if enabled
// - event flags clear only on written zero, never set by software
// - enable register holds overflow, alarm, second enables at bits 2..0
// - divider registers return live remaining count, read only
// - backup reset clears divider, reload and counter and sets the alarm to all ones; system reset clears control
// - reads valid only after one rtc rising edge following reset
// - sync flag bit 3 set by hardware, cleared by software
// - write-done bit 5 reads zero while a transfer is in flight
// - timekeeping writes only in config mode; leaving it starts transfer
// - both alarm halves reset to all ones
module backup_domain_rtc (
    input  wire logic        i_clk_sys,
    input  wire logic        i_srst,
    input  wire logic        i_bkp_srst,
    input  wire logic        i_rtc_input_clock,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [31:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    output logic             o_tick_pulse,
    output logic             o_second_irq,
    output logic             o_alarm_irq,
    output logic             o_overflow_irq
);

    typedef struct packed {
        // bus-side control and status
        logic [2:0]                                  irq_en;
        logic [2:0]                                  flags;
        logic                                        config_mode_bit;
        logic                                        sync_flag;
        logic                                        write_done;
        // staged halves waiting for transfer
        logic [backup_rtc_pkg::SLOT_COUNT-1:0][15:0] stage;
        logic [backup_rtc_pkg::SLOT_COUNT-1:0]       pend;
        // live timekeeping (backup domain), then read data, irq and tick flops
        logic [19:0]                                 divider;
        logic [19:0]                                 prescale_reload;
        logic [31:0]                                 time_counter;
        logic [31:0]                                 alarm_value;
        logic [15:0]                                 rdata;
        logic [2:0]                                  irq;
        logic                                        tick_pulse;
    } rtc_state_type;

    // registered state and its next value
    rtc_state_type q;
    rtc_state_type d;
    // synchronised rtc edge and decoded access
    logic          rtc_rise;
    logic [3:0]    acc_idx;
    logic          wr_access;

    // ========================================================================
    // address decode
    // ========================================================================
    function automatic logic [3:0] reg_index(input logic [31:0] addr);
        logic [3:0] idx;
        idx = no_index();
        // only word-aligned addresses inside the block map
        if (addr[31:6] == backup_rtc_pkg::ADDR_IRQ_ENABLE_CTRL[31:6] && addr[1:0] == 2'h0
                && addr[5:2] <= backup_rtc_pkg::IDX_ALARM_LOWER) begin
            idx = addr[5:2];
        end
        return idx;
    endfunction : reg_index

    // index returned for an unmapped address
    function automatic logic [3:0] no_index();
        return backup_rtc_pkg::IDX_NONE;
    endfunction : no_index

    // map a timekeeping register index to its staging slot
    function automatic int stage_slot(input logic [3:0] idx);
        int slot;
        // -1 marks a register that is not staged
        slot = -1;
        case (idx)
            backup_rtc_pkg::IDX_PRESCALE_UPPER: slot = backup_rtc_pkg::SLOT_RELOAD_UPPER;
            backup_rtc_pkg::IDX_PRESCALE_LOWER: slot = backup_rtc_pkg::SLOT_RELOAD_LOWER;
            backup_rtc_pkg::IDX_COUNTER_UPPER:  slot = backup_rtc_pkg::SLOT_COUNTER_UPPER;
            backup_rtc_pkg::IDX_COUNTER_LOWER:  slot = backup_rtc_pkg::SLOT_COUNTER_LOWER;
            backup_rtc_pkg::IDX_ALARM_UPPER:    slot = backup_rtc_pkg::SLOT_ALARM_UPPER;
            backup_rtc_pkg::IDX_ALARM_LOWER:    slot = backup_rtc_pkg::SLOT_ALARM_LOWER;
            default:                            slot = -1;
        endcase
        return slot;
    endfunction : stage_slot

    // ========================================================================
    // rtc clock crossing
    // ========================================================================
    // synchronised rtc edge
    rtc_clock_sync u_clock_sync (
        .i_clk_sys         (i_clk_sys),
        .i_srst            (i_srst),
        .i_rtc_input_clock (i_rtc_input_clock),
        .o_rtc_rise        (rtc_rise)
    );

    // register index and write strobe of the current access
    assign acc_idx   = reg_index(i_paddr);
    assign wr_access = i_psel & i_penable & i_pwrite;

    // ========================================================================
    // next-state logic
    // ========================================================================
    always_comb begin
        // per-cycle scratch values
        logic [2:0]  ev_set;
        logic [31:0] cnt_next;
        logic        sync_set;
        logic        tick;
        int          slot;
        // defaults: hold state, no pulse, no event
        ev_set       = 3'h0;
        cnt_next     = q.time_counter;
        sync_set     = 1'b0;
        tick         = 1'b0;
        slot         = -1;
        d            = q;
        d.tick_pulse = 1'b0;

        // rtc-edge work: divider, counter, transfer of staged writes
        if (rtc_rise) begin
            // sync flag rises on an rtc edge
            sync_set = 1'b1;
            if (q.divider == 20'h00000) begin
                tick      = 1'b1;
                d.divider = q.prescale_reload;
            end else begin
                d.divider = q.divider - 20'h00001;
            end
            if (tick) begin
                cnt_next                            = q.time_counter + 32'h0000_0001;
                d.tick_pulse                        = 1'b1;
                ev_set[backup_rtc_pkg::SECOND_BIT]  = 1'b1;
                ev_set[backup_rtc_pkg::OVERFLOW_BIT] = (q.time_counter == backup_rtc_pkg::COUNTER_MAX);
            end
            // staged values land in the counting logic
            if (!q.write_done) begin
                if (q.pend[backup_rtc_pkg::SLOT_RELOAD_UPPER]) begin
                    d.prescale_reload[19:16] = q.stage[backup_rtc_pkg::SLOT_RELOAD_UPPER][3:0];
                end
                if (q.pend[backup_rtc_pkg::SLOT_RELOAD_LOWER]) begin
                    d.prescale_reload[15:0] = q.stage[backup_rtc_pkg::SLOT_RELOAD_LOWER];
                end
                if (q.pend[backup_rtc_pkg::SLOT_COUNTER_UPPER]) begin
                    cnt_next[31:16] = q.stage[backup_rtc_pkg::SLOT_COUNTER_UPPER];
                end
                if (q.pend[backup_rtc_pkg::SLOT_COUNTER_LOWER]) begin
                    cnt_next[15:0] = q.stage[backup_rtc_pkg::SLOT_COUNTER_LOWER];
                end
                if (q.pend[backup_rtc_pkg::SLOT_ALARM_UPPER]) begin
                    d.alarm_value[31:16] = q.stage[backup_rtc_pkg::SLOT_ALARM_UPPER];
                end
                if (q.pend[backup_rtc_pkg::SLOT_ALARM_LOWER]) begin
                    d.alarm_value[15:0] = q.stage[backup_rtc_pkg::SLOT_ALARM_LOWER];
                end
                d.pend       = '0;
                d.write_done = 1'b1;
            end
            // a staged counter value replaces the increment
            d.time_counter = cnt_next;
            if (tick && cnt_next == d.alarm_value) begin
                ev_set[backup_rtc_pkg::ALARM_BIT] = 1'b1;
            end
        end

        // bus writes
        if (wr_access) begin
            case (acc_idx)
                backup_rtc_pkg::IDX_IRQ_ENABLE: begin
                    d.irq_en = i_pwdata[2:0];
                end
                backup_rtc_pkg::IDX_FLAGS_CONFIG: begin
                    d.flags = q.flags & i_pwdata[2:0];
                    if (!i_pwdata[backup_rtc_pkg::SYNC_FLAG_BIT]) begin
                        d.sync_flag = 1'b0;
                    end
                    // configuration bit follows the written value
                    d.config_mode_bit = i_pwdata[backup_rtc_pkg::CONFIG_MODE_BIT];
                    if (q.config_mode_bit && !i_pwdata[backup_rtc_pkg::CONFIG_MODE_BIT]) begin
                        d.write_done = 1'b0;
                    end
                end
                default: begin
                    // timekeeping registers go through staging
                    slot = stage_slot(acc_idx);
                    if (slot >= 0 && q.config_mode_bit) begin
                        d.stage[slot] = i_pwdata[15:0];
                        d.pend[slot]  = 1'b1;
                    end
                end
            endcase
        end

        // hardware set wins over software clear
        d.flags = d.flags | ev_set;
        // an rtc edge re-asserts sync even against a clear
        if (sync_set) begin
            d.sync_flag = 1'b1;
        end

        // read data captured in the setup phase
        if (i_psel && !i_penable) begin
            case (acc_idx)
                backup_rtc_pkg::IDX_IRQ_ENABLE:     d.rdata = {13'h0000, q.irq_en};
                backup_rtc_pkg::IDX_FLAGS_CONFIG:   d.rdata = {10'h000, q.write_done,
                    q.config_mode_bit, q.sync_flag, q.flags};
                // upper reload in low four bits
                backup_rtc_pkg::IDX_PRESCALE_UPPER: d.rdata = {12'h000, q.prescale_reload[19:16]};
                backup_rtc_pkg::IDX_PRESCALE_LOWER: d.rdata = q.prescale_reload[15:0];
                backup_rtc_pkg::IDX_DIVIDER_UPPER:  d.rdata = {12'h000, q.divider[19:16]};
                backup_rtc_pkg::IDX_DIVIDER_LOWER:  d.rdata = q.divider[15:0];
                backup_rtc_pkg::IDX_COUNTER_UPPER:  d.rdata = q.time_counter[31:16];
                backup_rtc_pkg::IDX_COUNTER_LOWER:  d.rdata = q.time_counter[15:0];
                backup_rtc_pkg::IDX_ALARM_UPPER:    d.rdata = q.alarm_value[31:16];
                backup_rtc_pkg::IDX_ALARM_LOWER:    d.rdata = q.alarm_value[15:0];
                default:                            d.rdata = 16'h0000;
            endcase
        end

        // interrupt lines follow flag and enable
        d.irq = d.flags & d.irq_en;

        if (i_bkp_srst) begin
            d.divider         = backup_rtc_pkg::RESET_DIVIDER;
            d.prescale_reload = backup_rtc_pkg::RESET_RELOAD;
            d.time_counter    = backup_rtc_pkg::RESET_COUNTER;
            d.alarm_value     = {backup_rtc_pkg::RESET_ALARM_HALF,
                                 backup_rtc_pkg::RESET_ALARM_HALF};
            d.tick_pulse      = 1'b0;
        end
        if (i_srst) begin
            d.irq_en          = backup_rtc_pkg::RESET_IRQ_ENABLE;
            d.flags           = backup_rtc_pkg::RESET_EVENT_FLAGS;
            d.config_mode_bit = 1'b0;
            d.sync_flag       = 1'b0;
            d.write_done      = 1'b1;
            d.stage           = '0;
            d.pend            = '0;
            d.rdata           = 16'h0000;
            d.irq             = 3'h0;
        end
    end

    // state register
    always_ff @(posedge i_clk_sys) begin
        q <= d;
    end

    // ========================================================================
    // outputs
    // ========================================================================
    // upper half of read data is always zero
    assign o_prdata       = {16'h0000, q.rdata};
    // no wait states
    assign o_pready       = 1'b1;
    // unmapped or misaligned address in the access phase
    assign o_pslverr      = i_psel & i_penable & (acc_idx == backup_rtc_pkg::IDX_NONE);
    // tick and interrupt lines straight from flops
    assign o_tick_pulse   = q.tick_pulse;
    assign o_second_irq   = q.irq[backup_rtc_pkg::SECOND_BIT];
    assign o_alarm_irq    = q.irq[backup_rtc_pkg::ALARM_BIT];
    assign o_overflow_irq = q.irq[backup_rtc_pkg::OVERFLOW_BIT];

endmodule : backup_domain_rtc

// ---- sim/backup_rtc_monitor.sv ----
`timescale 1ns/10ps

// ============================================================
// port checker for the rtc block
module backup_rtc_monitor (
    input wire logic        i_clk_sys,
    input wire logic        i_srst,
    input wire logic        i_bkp_srst,
    input wire logic        i_rtc_input_clock,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        o_tick_pulse,
    input wire logic        o_second_irq,
    input wire logic        o_alarm_irq,
    input wire logic        o_overflow_irq
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_srst || i_bkp_srst);

    // a register write ends at this edge
    logic wr_end;
    assign wr_end = i_psel && i_penable && i_pwrite;

    tick_gap_a: assert property (o_tick_pulse |=> !o_tick_pulse [*5])
        else $error("tick pulses too close");
    sec_rise_a: assert property ($rose(o_second_irq) |->
        o_tick_pulse || $past(o_tick_pulse) || $past(wr_end) || $past(wr_end, 2))
        else $error("second irq rose without a tick");
    alarm_rise_a: assert property ($rose(o_alarm_irq) |->
        o_tick_pulse || $past(o_tick_pulse) || $past(wr_end) || $past(wr_end, 2))
        else $error("alarm irq rose without a tick");
    ovf_rise_a: assert property ($rose(o_overflow_irq) |->
        o_tick_pulse || $past(o_tick_pulse) || $past(wr_end) || $past(wr_end, 2))
        else $error("overflow irq rose without a tick");
    irq_fall_a: assert property ($fell(o_second_irq) || $fell(o_alarm_irq) ||
        $fell(o_overflow_irq) |-> $past(wr_end) || $past(wr_end, 2))
        else $error("irq fell without a register write");
    bad_addr_a: assert property (
        i_psel && i_penable && i_paddr == 32'h4000_2828 |-> o_pslverr)
        else $error("unmapped access not flagged");
    err_scope_a: assert property (o_pslverr |-> i_psel && i_penable)
        else $error("slave error outside access phase");
    rdata_upper_a: assert property (o_prdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");
endmodule : backup_rtc_monitor

// ---- sim/apb_host_model.sv ----
`timescale 1ns/10ps

// ============================================================
// bus host standing in for the processor
module apb_host_model (
    input  wire logic        i_clk_sys,
    input  wire logic [31:0] i_prdata,
    input  wire logic        i_pready,
    input  wire logic        i_pslverr,
    output logic             o_psel,
    output logic             o_penable,
    output logic             o_pwrite,
    output logic      [31:0] o_paddr,
    output logic      [31:0] o_pwdata
);
    // idle bus at time zero
    initial begin
        o_psel    = 1'b0;
        o_penable = 1'b0;
        o_pwrite  = 1'b0;
        o_paddr   = 32'h0000_0000;
        o_pwdata  = 32'h0000_0000;
    end

    // one setup plus access cycle, released address shows inverted
    task xfer(input logic w, input logic [31:0] a, input logic [15:0] d,
              output logic [15:0] rd, output logic err);
        int t;
        @(posedge i_clk_sys);
        o_psel    <= 1'b1;
        o_penable <= 1'b0;
        o_pwrite  <= w;
        o_paddr   <= a;
        o_pwdata  <= {16'h0000, d};
        @(posedge i_clk_sys);
        o_penable <= 1'b1;
        t = 0;
        do begin
            @(posedge i_clk_sys);
            t++;
        end while (i_pready !== 1'b1 && t < 16);
        rd = i_prdata[15:0];
        err = i_pslverr | (i_pready !== 1'b1);
        o_psel    <= 1'b0;
        o_penable <= 1'b0;
        o_paddr   <= ~a;
        o_pwdata  <= ~{16'h0000, d};
    endtask : xfer

    task poll_done(output logic ok);
        logic [15:0] d;
        logic        e;
        ok = 1'b0;
        for (int i = 0; i < 64 && !ok; i++) begin
            xfer(1'b0, backup_rtc_pkg::ADDR_FLAGS_CONFIG_CTRL, 16'h0000, d, e);
            ok = (d[backup_rtc_pkg::WRITE_DONE_BIT] === 1'b1);
        end
    endtask : poll_done
endmodule : apb_host_model

// ---- sim/backup_domain_rtc_tb_top.sv ----
`timescale 1ns/10ps

// ============================================================
// top of the rtc bench
module backup_domain_rtc_tb_top;
    typedef struct {logic [31:0] a; logic [15:0] d; logic e;} row_type;
    logic        clk, srst, bkp_srst, rtc_run, psel, penable, pwrite;
    logic        rtc_clk = 1'b0;
    logic        pready, pslverr, tick, sec_irq, alm_irq, ovf_irq, ok;
    logic [31:0] paddr, pwdata, prdata;
    logic [15:0] rdv;
    int          errors, checks_done, cycles, n, k;
    // register order: irq, flags, reload u/l, divider u/l, counter u/l, alarm u/l, unmapped
    row_type rows [11] = '{'{32'h4000_2800, 16'h0000, 1'b0}, '{32'h4000_2804, 16'h0020, 1'b0},
        '{32'h4000_2808, 16'h0000, 1'b0}, '{32'h4000_280c, 16'h0000, 1'b0},
        '{32'h4000_2810, 16'h0000, 1'b0}, '{32'h4000_2814, 16'h0000, 1'b0},
        '{32'h4000_2818, 16'h0000, 1'b0}, '{32'h4000_281c, 16'h0000, 1'b0},
        '{32'h4000_2820, 16'hffff, 1'b0}, '{32'h4000_2824, 16'hffff, 1'b0},
        '{32'h4000_2828, 16'h0000, 1'b1}};

    backup_domain_rtc dut_u (.i_clk_sys(clk), .i_srst(srst), .i_bkp_srst(bkp_srst),
        .i_rtc_input_clock(rtc_clk), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_tick_pulse(tick), .o_second_irq(sec_irq),
        .o_alarm_irq(alm_irq), .o_overflow_irq(ovf_irq));
    apb_host_model host_u (.i_clk_sys(clk), .i_prdata(prdata), .i_pready(pready),
        .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
        .o_paddr(paddr), .o_pwdata(pwdata));

    // system clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // rtc clock, 16 system cycles a period, always parks low
    always @(posedge clk) begin
        k <= (k == 7) ? 0 : k + 1;
        if ((rtc_run || rtc_clk) && k == 7) rtc_clk <= ~rtc_clk;
    end

    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            final_report();
        end
    end

    // ============================================================
    // helpers
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task rchk(input logic [31:0] a, input logic [15:0] exp);
        logic e;
        host_u.xfer(1'b0, a, 16'h0000, rdv, e);
        chk(rdv, exp);
    endtask : rchk
    task wr(input logic [31:0] a, input logic [15:0] d);
        logic [15:0] x;
        logic        e;
        host_u.xfer(1'b1, a, d, x, e);
    endtask : wr
    task wait_for(input int sel);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((sel ? ovf_irq : tick) !== 1'b1 && n < 500);
    endtask : wait_for
    task final_report;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    // ============================================================
    // main sequence
    initial begin
        srst = 1'b1;
        bkp_srst = 1'b1;
        rtc_run = 1'b0;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        bkp_srst <= 1'b0;
        // reset values and unmapped address
        for (int i = 0; i < 11; i++) begin
            host_u.xfer(1'b0, rows[i].a, 16'h0000, rdv, ok);
            chk(rdv, rows[i].d); // reset value
            chk({15'h0000, ok}, {15'h0000, rows[i].e}); // address map
        end
        wr(rows[7].a, 16'h1234);
        rchk(rows[7].a, 16'h0000); // locked write
        wr(rows[5].a, 16'h5555);
        rchk(rows[5].a, 16'h0000); // read only
        wr(rows[0].a, 16'hffff);
        rchk(rows[0].a, 16'h0007); // enable bits
        host_u.poll_done(ok);
        chk({15'h0000, ok}, 16'h0001); // idle done
        wr(rows[1].a, 16'h0010);
        wr(rows[2].a, 16'h0010);
        wr(rows[3].a, 16'h0002);
        wr(rows[6].a, 16'hffff);
        wr(rows[7].a, 16'hfffe);
        wr(rows[8].a, 16'h0000);
        wr(rows[9].a, 16'h0000);
        wr(rows[1].a, 16'h0000);
        rchk(rows[1].a, 16'h0000); // transfer pending
        rtc_run <= 1'b1;
        host_u.poll_done(ok);
        chk({15'h0000, ok}, 16'h0001); // transfer done
        rchk(rows[2].a, 16'h0000); // upper nibble only
        rchk(rows[3].a, 16'h0002); // lower half
        wait_for(1);
        chk({15'h0000, ovf_irq}, 16'h0001); // overflow irq
        chk({15'h0000, alm_irq}, 16'h0001); // match at wrap
        rchk(rows[7].a, 16'h0000); // counter wrapped
        rchk(rows[6].a, 16'h0000); // upper wrapped
        rchk(rows[1].a, 16'h002f); // flags set
        wr(rows[1].a, 16'h0000);
        wr(rows[1].a, 16'h0007);
        host_u.xfer(1'b0, rows[1].a, 16'h0000, rdv, ok);
        chk(rdv & 16'h0006, 16'h0000); // clear only
        chk({15'h0000, alm_irq}, 16'h0000); // irq follows flag
        wait_for(0);
        wait_for(0);
        chk(n[15:0], 16'h0030); // ratio three
        chk({15'h0000, sec_irq}, 16'h0001); // second irq
        host_u.xfer(1'b0, rows[5].a, 16'h0000, rdv, ok);
        chk({15'h0000, rdv <= 16'h0002}, 16'h0001); // live count
        rtc_run <= 1'b0;
        repeat (20) @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rchk(rows[0].a, 16'h0000); // control cleared
        rchk(rows[1].a, 16'h0020); // sync low
        host_u.xfer(1'b0, rows[7].a, 16'h0000, rdv, ok);
        chk({15'h0000, rdv == 16'h0000}, 16'h0000); // counter kept
        rtc_run <= 1'b1;
        repeat (40) @(posedge clk);
        host_u.xfer(1'b0, rows[1].a, 16'h0000, rdv, ok);
        chk(rdv & 16'h0008, 16'h0008); // sync set
        final_report();
    end
endmodule : backup_domain_rtc_tb_top

bind backup_domain_rtc backup_rtc_monitor mon_u (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
    .i_bkp_srst(i_bkp_srst), .i_rtc_input_clock(i_rtc_input_clock), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_tick_pulse(o_tick_pulse), .o_second_irq(o_second_irq), .o_alarm_irq(o_alarm_irq),
    .o_overflow_irq(o_overflow_irq));
